/* verilog/nfc_defs.svh */
// constants for the nand flash host controller: timing, geometry and command codes
`ifndef NFC_DEFS_SVH
`define NFC_DEFS_SVH

`define NFC_CLK_NS 40
`define NFC_CEIL(t) (((t) + `NFC_CLK_NS - 1) / `NFC_CLK_NS)
`define NFC_FLOOR(t) ((t) / `NFC_CLK_NS)

// write strobe low time, least
`define NFC_T_WP_NS 15
`define NFC_WP_CYC `NFC_CEIL(`NFC_T_WP_NS)
// write strobe to busy, longest; ready/busy is not trusted before this
`define NFC_T_WB_NS 100
`define NFC_WB_CYC `NFC_CEIL(`NFC_T_WB_NS)
// turnaround gap: longest of address-to-data, read-to-write and write-to-read
`define NFC_T_GAP_NS 100
`define NFC_GAP_CYC `NFC_CEIL(`NFC_T_GAP_NS)
// pin synchroniser depth
`define NFC_SYNC_CYC 2
// read strobe low time covers access time plus the synchroniser
`define NFC_RD_CYC (`NFC_SYNC_CYC + 1)

// array geometry
`define NFC_PAGE_MAIN 4096
`define NFC_PAGE_SPARE 218
`define NFC_PAGE_BYTES (`NFC_PAGE_MAIN + `NFC_PAGE_SPARE)
`define NFC_COL_W 13
`define NFC_PG_W 6
`define NFC_BLK_W 12
`define NFC_ROW_W (`NFC_PG_W + `NFC_BLK_W)

// sequencer phase numbering: five phases per segment, then read, then end
`define NFC_PH_SEG 4'h5
`define NFC_PH_RD 4'hA
`define NFC_PH_END 4'hB

// command codes
`define NFC_C_NONE 8'h00
`define NFC_C_READ 8'h00
`define NFC_C_READ_GO 8'h30
`define NFC_C_CB_READ_GO 8'h35
`define NFC_C_PROG 8'h80
`define NFC_C_PROG_GO 8'h10
`define NFC_C_CB_PROG 8'h85
`define NFC_C_ERASE 8'h60
`define NFC_C_ERASE_GO 8'hD0
`define NFC_C_READ_ID 8'h90
`define NFC_C_RESET 8'hFF
`define NFC_C_STATUS 8'h70
`define NFC_C_STATUS2 8'hF1
`define NFC_C_RAND_OUT 8'h05
`define NFC_C_RAND_OUT_GO 8'hE0
`define NFC_C_PLANE_JOIN 8'h11
`define NFC_C_PLANE2 8'h81
`define NFC_C_CACHE_PROG_GO 8'h15
`define NFC_C_CACHE_READ 8'h31
`define NFC_C_CACHE_LAST 8'h3F
`define NFC_C_TP_CACHE_GO 8'h33
`define NFC_ID_ADDR 8'h00

`endif

/* verilog/nfc_pkg.sv */
// types shared by the nand flash host controller modules
package nfc_pkg;

	typedef enum logic [4:0] {
		OP_RESET = 5'h00,
		OP_STATUS = 5'h01,
		OP_STATUS2 = 5'h02,
		OP_READ_ID = 5'h03,
		OP_READ = 5'h04,
		OP_READ_CB = 5'h05,
		OP_PROG = 5'h06,
		OP_PROG_CACHE = 5'h07,
		OP_CB_PROG = 5'h08,
		OP_CB_PROG_RAND = 5'h09,
		OP_ERASE = 5'h0A,
		OP_RAND_OUT = 5'h0B,
		OP_CACHE_READ = 5'h0C,
		OP_CACHE_LAST = 5'h0D,
		OP_TP_READ = 5'h0E,
		OP_TP_CB_READ = 5'h0F,
		OP_TP_CACHE_READ = 5'h10,
		OP_TP_ERASE = 5'h11,
		OP_TP_PROG = 5'h12,
		OP_TP_CACHE_PROG = 5'h13,
		OP_TP_CB_PROG = 5'h14,
		OP_TP_RAND_OUT = 5'h15
	} nfc_op_e;

	typedef enum logic [2:0] {
		A_NONE = 3'b000,
		A_ONE = 3'b001,
		A_COL = 3'b010,
		A_ROW = 3'b011,
		A_FULL = 3'b100
	} nfc_addr_e;

	typedef enum logic [1:0] {
		RD_NONE = 2'b00,
		RD_ONE = 2'b01,
		RD_LEN = 2'b10
	} nfc_rd_e;

	typedef struct packed {
		logic cmd_en;
		logic [7:0] cmd;
		nfc_addr_e addr;
		logic wr;
		logic cmd2_en;
		logic [7:0] cmd2;
		logic wt;
	} nfc_seg_s;

	typedef struct packed {
		nfc_seg_s pa;
		nfc_seg_s pb;
		nfc_rd_e rd;
	} nfc_plan_s;

	typedef enum logic [2:0] {
		PH_CMD = 3'b000,
		PH_ADDR = 3'b001,
		PH_WR = 3'b010,
		PH_CMD2 = 3'b011,
		PH_WAIT = 3'b100,
		PH_RD = 3'b101,
		PH_END = 3'b110
	} nfc_ph_e;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_PHASE = 3'b001,
		ST_GAP = 3'b010,
		ST_ISSUE = 3'b011,
		ST_CYC = 3'b100,
		ST_WB = 3'b101,
		ST_RB = 3'b110,
		ST_WRHS = 3'b111
	} nfc_st_e;

	typedef enum logic [1:0] {
		CY_IDLE = 2'b00,
		CY_SETUP = 2'b01,
		CY_LOW = 2'b10,
		CY_HIGH = 2'b11
	} nfc_cy_e;

endpackage

/* verilog/nfc_cyc_if.sv */
// bus-cycle request and answer between the sequencer and the pin cycle engine
`timescale 1ns/1ps
interface nfc_cyc_if;
	logic req;
	logic rd;
	logic cle;
	logic ale;
	logic [7:0] wbyte;
	logic done;
	logic [7:0] rbyte;
	logic rb;

	modport seq (output req, output rd, output cle, output ale, output wbyte,
		input done, input rbyte, input rb);
	modport eng (input req, input rd, input cle, input ale, input wbyte,
		output done, output rbyte, output rb);
endinterface

/* verilog/nfc_cycle.sv */
// pin cycle engine: one write or read strobe cycle per request, with input synchronisers
`timescale 1ns/1ps
`include "nfc_defs.svh"
module nfc_cycle (
	input wire logic clk,
	input wire logic resetn,
	nfc_cyc_if.eng cyc,
	output logic nand_cle,
	output logic nand_ale,
	output logic nand_we_n,
	output logic read_strobe_n,
	output logic [7:0] nand_io_out,
	output logic nand_io_oe,
	input wire logic [7:0] nand_io_in,
	input wire logic nand_rb_n
);
	nfc_pkg::nfc_cy_e state;
	logic [1:0] cnt;
	logic rd_q;
	logic [7:0] io_s1;
	logic [7:0] io_s2;
	logic rb_s1;
	logic rb_s2;
	logic done_q;
	logic [7:0] rbyte_q;

	assign cyc.done = done_q;
	assign cyc.rbyte = rbyte_q;
	assign cyc.rb = rb_s2;

	// ready/busy is open drain; the board pull-up makes the high level
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			io_s1 <= 8'h00;
			io_s2 <= 8'h00;
			rb_s1 <= 1'b0;
			rb_s2 <= 1'b0;
		end else begin
			io_s1 <= nand_io_in;
			io_s2 <= io_s1;
			rb_s1 <= nand_rb_n;
			rb_s2 <= rb_s1;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state <= nfc_pkg::CY_IDLE;
			cnt <= 2'h0;
			rd_q <= 1'b0;
			done_q <= 1'b0;
			rbyte_q <= 8'h00;
			nand_cle <= 1'b0;
			nand_ale <= 1'b0;
			nand_we_n <= 1'b1;
			read_strobe_n <= 1'b1;
			nand_io_out <= 8'h00;
			nand_io_oe <= 1'b0;
		end else begin
			done_q <= 1'b0;
			case (state)
				nfc_pkg::CY_IDLE: begin
					if (cyc.req) begin
						nand_cle <= cyc.cle;
						nand_ale <= cyc.ale;
						nand_io_out <= cyc.wbyte;
						// bus released before a read so the device may drive it
						nand_io_oe <= !cyc.rd;
						rd_q <= cyc.rd;
						state <= nfc_pkg::CY_SETUP;
					end else begin
						nand_io_oe <= 1'b0;
					end
				end
				nfc_pkg::CY_SETUP: begin
					if (rd_q) begin
						read_strobe_n <= 1'b0;
						cnt <= 2'(`NFC_RD_CYC - 1);
					end else begin
						nand_we_n <= 1'b0;
						cnt <= 2'(`NFC_WP_CYC - 1);
					end
					state <= nfc_pkg::CY_LOW;
				end
				nfc_pkg::CY_LOW: begin
					if (cnt == 2'h0) begin
						nand_we_n <= 1'b1;
						read_strobe_n <= 1'b1;
						if (rd_q) begin
							rbyte_q <= io_s2;
						end
						state <= nfc_pkg::CY_HIGH;
					end else begin
						cnt <= cnt - 2'h1;
					end
				end
				nfc_pkg::CY_HIGH: begin
					// latch enables and data held one cycle past the rising strobe
					done_q <= 1'b1;
					nand_cle <= 1'b0;
					nand_ale <= 1'b0;
					state <= nfc_pkg::CY_IDLE;
				end
				default: begin
					state <= nfc_pkg::CY_IDLE;
				end
			endcase
		end
	end
endmodule

/* verilog/nfc_host.sv */
// nand flash host controller: sequences commands, addresses and data onto the flash pins
`timescale 1ns/1ps
`include "nfc_defs.svh"
module nfc_host #(
	parameter int NBAD = 8
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic req_valid,
	input wire nfc_pkg::nfc_op_e req_op,
	input wire logic [`NFC_ROW_W-1:0] req_row,
	input wire logic [`NFC_ROW_W-1:0] req_row2,
	input wire logic [`NFC_COL_W-1:0] req_col,
	input wire logic [`NFC_COL_W-1:0] req_len,
	output logic req_ready,
	input wire logic [7:0] wr_data,
	input wire logic wr_valid,
	output logic wr_ready,
	output logic [7:0] rd_data,
	output logic rd_valid,
	output logic done,
	output logic refused,
	input wire logic bad_wr,
	input wire logic [`NFC_BLK_W-1:0] bad_blk,
	input wire logic write_protect,
	output logic nand_ce_n,
	output logic nand_cle,
	output logic nand_ale,
	output logic nand_we_n,
	output logic read_strobe_n,
	output logic nand_wp_n,
	output logic [7:0] nand_io_out,
	output logic nand_io_oe,
	input wire logic [7:0] nand_io_in,
	input wire logic nand_rb_n
);
	localparam int BADW = (NBAD > 1) ? $clog2(NBAD) : 1;

	nfc_cyc_if cyc ();

	nfc_pkg::nfc_st_e st;
	nfc_pkg::nfc_op_e op;
	nfc_pkg::nfc_plan_s plan;
	nfc_pkg::nfc_seg_s seg;
	nfc_pkg::nfc_ph_e kind;
	logic [3:0] ph;
	logic [3:0] sel;
	logic en;
	logic [`NFC_ROW_W-1:0] row;
	logic [`NFC_ROW_W-1:0] row2;
	logic [`NFC_COL_W-1:0] col;
	logic [`NFC_COL_W-1:0] len;
	logic [`NFC_COL_W-1:0] sub;
	logic [`NFC_COL_W-1:0] last;
	logic [1:0] gapcnt;
	logic [2:0] wbcnt;
	logic [7:0] byte_q;
	logic tp_read_ok;
	logic refuse_now;
	logic [`NFC_BLK_W-1:0] bad_tab [NBAD];
	logic [NBAD-1:0] bad_vld;
	logic [BADW-1:0] bad_ptr;
	logic req_q;
	logic rd_q;
	logic cle_q;
	logic ale_q;
	logic [7:0] wbyte_q;

	assign cyc.req = req_q;
	assign cyc.rd = rd_q;
	assign cyc.cle = cle_q;
	assign cyc.ale = ale_q;
	assign cyc.wbyte = wbyte_q;

	nfc_cycle u_cycle (
		.clk(clk),
		.resetn(resetn),
		.cyc(cyc.eng),
		.nand_cle(nand_cle),
		.nand_ale(nand_ale),
		.nand_we_n(nand_we_n),
		.read_strobe_n(read_strobe_n),
		.nand_io_out(nand_io_out),
		.nand_io_oe(nand_io_oe),
		.nand_io_in(nand_io_in),
		.nand_rb_n(nand_rb_n)
	);

	function automatic nfc_pkg::nfc_seg_s mkseg(logic e1, logic [7:0] c1, nfc_pkg::nfc_addr_e a,
		logic w, logic e2, logic [7:0] c2, logic t);
		nfc_pkg::nfc_seg_s s;
		s.cmd_en = e1;
		s.cmd = c1;
		s.addr = a;
		s.wr = w;
		s.cmd2_en = e2;
		s.cmd2 = c2;
		s.wt = t;
		return s;
	endfunction

	// plane A segment is used only by two-plane operations
	function automatic nfc_pkg::nfc_plan_s op_plan(nfc_pkg::nfc_op_e o);
		nfc_pkg::nfc_plan_s p;
		p = '0;
		case (o)
			nfc_pkg::OP_RESET: begin
				p.pb = mkseg(1'b1, `NFC_C_RESET, nfc_pkg::A_NONE, 1'b0, 1'b0, `NFC_C_NONE, 1'b1);
			end
			nfc_pkg::OP_STATUS: begin
				p.pb = mkseg(1'b1, `NFC_C_STATUS, nfc_pkg::A_NONE, 1'b0, 1'b0, `NFC_C_NONE, 1'b0);
				p.rd = nfc_pkg::RD_ONE;
			end
			nfc_pkg::OP_STATUS2: begin
				p.pb = mkseg(1'b1, `NFC_C_STATUS2, nfc_pkg::A_NONE, 1'b0, 1'b0, `NFC_C_NONE, 1'b0);
				p.rd = nfc_pkg::RD_ONE;
			end
			nfc_pkg::OP_READ_ID: begin
				p.pb = mkseg(1'b1, `NFC_C_READ_ID, nfc_pkg::A_ONE, 1'b0, 1'b0, `NFC_C_NONE, 1'b0);
				p.rd = nfc_pkg::RD_LEN;
			end
			nfc_pkg::OP_READ: begin
				p.pb = mkseg(1'b1, `NFC_C_READ, nfc_pkg::A_FULL, 1'b0, 1'b1, `NFC_C_READ_GO, 1'b1);
				p.rd = nfc_pkg::RD_LEN;
			end
			nfc_pkg::OP_READ_CB: begin
				p.pb = mkseg(1'b1, `NFC_C_READ, nfc_pkg::A_FULL, 1'b0, 1'b1, `NFC_C_CB_READ_GO, 1'b1);
			end
			nfc_pkg::OP_PROG: begin
				p.pb = mkseg(1'b1, `NFC_C_PROG, nfc_pkg::A_FULL, 1'b1, 1'b1, `NFC_C_PROG_GO, 1'b1);
			end
			nfc_pkg::OP_PROG_CACHE: begin
				p.pb = mkseg(1'b1, `NFC_C_PROG, nfc_pkg::A_FULL, 1'b1, 1'b1, `NFC_C_CACHE_PROG_GO, 1'b1);
			end
			nfc_pkg::OP_CB_PROG: begin
				p.pb = mkseg(1'b1, `NFC_C_CB_PROG, nfc_pkg::A_FULL, 1'b0, 1'b1, `NFC_C_PROG_GO, 1'b1);
			end
			nfc_pkg::OP_CB_PROG_RAND: begin
				p.pb = mkseg(1'b1, `NFC_C_CB_PROG, nfc_pkg::A_FULL, 1'b1, 1'b1, `NFC_C_PROG_GO, 1'b1);
			end
			nfc_pkg::OP_ERASE: begin
				p.pb = mkseg(1'b1, `NFC_C_ERASE, nfc_pkg::A_ROW, 1'b0, 1'b1, `NFC_C_ERASE_GO, 1'b1);
			end
			nfc_pkg::OP_RAND_OUT: begin
				p.pb = mkseg(1'b1, `NFC_C_RAND_OUT, nfc_pkg::A_COL, 1'b0, 1'b1, `NFC_C_RAND_OUT_GO, 1'b0);
				p.rd = nfc_pkg::RD_LEN;
			end
			nfc_pkg::OP_CACHE_READ: begin
				p.pb = mkseg(1'b1, `NFC_C_CACHE_READ, nfc_pkg::A_NONE, 1'b0, 1'b0, `NFC_C_NONE, 1'b1);
				p.rd = nfc_pkg::RD_LEN;
			end
			nfc_pkg::OP_CACHE_LAST: begin
				p.pb = mkseg(1'b1, `NFC_C_CACHE_LAST, nfc_pkg::A_NONE, 1'b0, 1'b0, `NFC_C_NONE, 1'b1);
				p.rd = nfc_pkg::RD_LEN;
			end
			nfc_pkg::OP_TP_READ, nfc_pkg::OP_TP_CB_READ, nfc_pkg::OP_TP_CACHE_READ,
			nfc_pkg::OP_TP_ERASE: begin
				p.pa = mkseg(1'b1, `NFC_C_ERASE, nfc_pkg::A_ROW, 1'b0, 1'b0, `NFC_C_NONE, 1'b0);
				p.pb = mkseg(1'b1, `NFC_C_ERASE, nfc_pkg::A_ROW, 1'b0, 1'b1, `NFC_C_READ_GO, 1'b1);
				if (o == nfc_pkg::OP_TP_CB_READ) begin
					p.pb.cmd2 = `NFC_C_CB_READ_GO;
				end else if (o == nfc_pkg::OP_TP_CACHE_READ) begin
					p.pb.cmd2 = `NFC_C_TP_CACHE_GO;
				end else if (o == nfc_pkg::OP_TP_ERASE) begin
					p.pb.cmd2 = `NFC_C_ERASE_GO;
				end
			end
			nfc_pkg::OP_TP_PROG, nfc_pkg::OP_TP_CACHE_PROG, nfc_pkg::OP_TP_CB_PROG: begin
				// only the short dummy busy wait sits between join and second plane
				p.pa = mkseg(1'b1, `NFC_C_PROG, nfc_pkg::A_FULL, 1'b1, 1'b1, `NFC_C_PLANE_JOIN, 1'b1);
				p.pb = mkseg(1'b1, `NFC_C_PLANE2, nfc_pkg::A_FULL, 1'b1, 1'b1, `NFC_C_PROG_GO, 1'b1);
				if (o == nfc_pkg::OP_TP_CACHE_PROG) begin
					p.pb.cmd2 = `NFC_C_CACHE_PROG_GO;
				end else if (o == nfc_pkg::OP_TP_CB_PROG) begin
					p.pa.cmd = `NFC_C_CB_PROG;
					p.pa.wr = 1'b0;
					p.pb.wr = 1'b0;
				end
			end
			nfc_pkg::OP_TP_RAND_OUT: begin
				p.pa = mkseg(1'b1, `NFC_C_READ, nfc_pkg::A_FULL, 1'b0, 1'b0, `NFC_C_NONE, 1'b0);
				p.pb = mkseg(1'b1, `NFC_C_RAND_OUT, nfc_pkg::A_COL, 1'b0, 1'b1, `NFC_C_RAND_OUT_GO, 1'b0);
				p.rd = nfc_pkg::RD_LEN;
			end
			default: begin
				p = '0;
			end
		endcase
		return p;
	endfunction

	function automatic logic [2:0] addr_n(nfc_pkg::nfc_addr_e k);
		case (k)
			nfc_pkg::A_ONE: addr_n = 3'h1;
			nfc_pkg::A_COL: addr_n = 3'h2;
			nfc_pkg::A_ROW: addr_n = 3'h3;
			default: addr_n = 3'h5;
		endcase
	endfunction

	// column bits A13-A15 and the top six bits of the fifth byte go out as zero
	function automatic logic [7:0] addr_byte(nfc_pkg::nfc_addr_e k, logic [2:0] i,
		logic [`NFC_ROW_W-1:0] r, logic [`NFC_COL_W-1:0] c);
		logic [39:0] a;
		logic [2:0] j;
		a = {6'h00, r, 3'h0, c};
		j = (k == nfc_pkg::A_ROW) ? 3'(i + 3'h2) : i;
		if (k == nfc_pkg::A_ONE) begin
			return `NFC_ID_ADDR;
		end
		return a[j*8 +: 8];
	endfunction

	function automatic logic is_bad(logic [`NFC_BLK_W-1:0] b, logic [NBAD-1:0] v,
		logic [`NFC_BLK_W-1:0] t [NBAD]);
		logic hit;
		hit = 1'b0;
		for (int k = 0; k < NBAD; k++) begin
			hit = hit | (v[k] && (t[k] == b));
		end
		return hit;
	endfunction

	always_comb begin
		seg = (ph < `NFC_PH_SEG) ? plan.pa : plan.pb;
		sel = (ph < `NFC_PH_SEG) ? ph : 4'(ph - `NFC_PH_SEG);
		if (ph >= `NFC_PH_END) begin
			kind = nfc_pkg::PH_END;
		end else if (ph == `NFC_PH_RD) begin
			kind = nfc_pkg::PH_RD;
		end else begin
			kind = nfc_pkg::nfc_ph_e'(sel[2:0]);
		end
		case (kind)
			nfc_pkg::PH_CMD: en = seg.cmd_en;
			nfc_pkg::PH_ADDR: en = (seg.addr != nfc_pkg::A_NONE);
			nfc_pkg::PH_WR: en = seg.wr && (len != '0);
			nfc_pkg::PH_CMD2: en = seg.cmd2_en;
			nfc_pkg::PH_WAIT: en = seg.wt;
			nfc_pkg::PH_RD: en = (plan.rd != nfc_pkg::RD_NONE) && !(plan.rd == nfc_pkg::RD_LEN && len == '0);
			default: en = 1'b1;
		endcase
		case (kind)
			nfc_pkg::PH_ADDR: last = `NFC_COL_W'(addr_n(seg.addr)) - 1'b1;
			nfc_pkg::PH_RD: last = (plan.rd == nfc_pkg::RD_ONE) ? '0 : len - 1'b1;
			default: last = len - 1'b1;
		endcase
	end

	always_comb begin
		refuse_now = 1'b0;
		// data may not run past the end of the page
		if (({1'b0, req_col} + {1'b0, req_len}) > 14'(`NFC_PAGE_BYTES)) begin
			refuse_now = (req_op != nfc_pkg::OP_READ_ID);
		end
		case (req_op)
			nfc_pkg::OP_PROG, nfc_pkg::OP_PROG_CACHE, nfc_pkg::OP_CB_PROG, nfc_pkg::OP_CB_PROG_RAND,
			nfc_pkg::OP_ERASE, nfc_pkg::OP_TP_ERASE, nfc_pkg::OP_TP_PROG,
			nfc_pkg::OP_TP_CACHE_PROG, nfc_pkg::OP_TP_CB_PROG: begin
				if (is_bad(req_row[`NFC_ROW_W-1:`NFC_PG_W], bad_vld, bad_tab)) begin
					refuse_now = 1'b1;
				end
				if (req_op >= nfc_pkg::OP_TP_ERASE
					&& is_bad(req_row2[`NFC_ROW_W-1:`NFC_PG_W], bad_vld, bad_tab)) begin
					refuse_now = 1'b1;
				end
			end
			nfc_pkg::OP_TP_RAND_OUT: begin
				refuse_now = refuse_now | !tp_read_ok;
			end
			default: begin
			end
		endcase
	end

	// software-loaded list of blocks that program and erase requests must keep away from
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			bad_vld <= '0;
			bad_ptr <= '0;
			for (int k = 0; k < NBAD; k++) begin
				bad_tab[k] <= '0;
			end
		end else if (bad_wr) begin
			bad_tab[bad_ptr] <= bad_blk;
			bad_vld[bad_ptr] <= 1'b1;
			bad_ptr <= (bad_ptr == BADW'(NBAD - 1)) ? '0 : bad_ptr + 1'b1;
		end
	end

	// protection is held until reset is over and the input says otherwise
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			nand_wp_n <= 1'b0;
		end else begin
			nand_wp_n <= !write_protect;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st <= nfc_pkg::ST_IDLE;
			op <= nfc_pkg::OP_RESET;
			plan <= '0;
			ph <= 4'h0;
			row <= '0;
			row2 <= '0;
			col <= '0;
			len <= '0;
			sub <= '0;
			gapcnt <= 2'h0;
			wbcnt <= 3'h0;
			byte_q <= 8'h00;
			tp_read_ok <= 1'b0;
			req_ready <= 1'b0;
			wr_ready <= 1'b0;
			rd_data <= 8'h00;
			rd_valid <= 1'b0;
			done <= 1'b0;
			refused <= 1'b0;
			nand_ce_n <= 1'b1;
			req_q <= 1'b0;
			rd_q <= 1'b0;
			cle_q <= 1'b0;
			ale_q <= 1'b0;
			wbyte_q <= 8'h00;
		end else begin
			done <= 1'b0;
			refused <= 1'b0;
			rd_valid <= 1'b0;
			wr_ready <= 1'b0;
			req_q <= 1'b0;
			case (st)
				nfc_pkg::ST_IDLE: begin
					req_ready <= 1'b1;
					nand_ce_n <= 1'b1;
					if (req_valid && req_ready) begin
						req_ready <= 1'b0;
						if (refuse_now) begin
							refused <= 1'b1;
						end else begin
							op <= req_op;
							row <= req_row;
							row2 <= req_row2;
							col <= req_col;
							len <= req_len;
							plan <= op_plan(req_op);
							ph <= 4'h0;
							nand_ce_n <= 1'b0;
							st <= nfc_pkg::ST_PHASE;
							if (req_op != nfc_pkg::OP_TP_RAND_OUT && req_op != nfc_pkg::OP_STATUS
								&& req_op != nfc_pkg::OP_STATUS2) begin
								tp_read_ok <= 1'b0;
							end
						end
					end
				end
				nfc_pkg::ST_PHASE: begin
					sub <= '0;
					gapcnt <= 2'(`NFC_GAP_CYC - 1);
					if (kind == nfc_pkg::PH_END) begin
						done <= 1'b1;
						if (op == nfc_pkg::OP_TP_READ || op == nfc_pkg::OP_TP_CACHE_READ) begin
							tp_read_ok <= 1'b1;
						end
						st <= nfc_pkg::ST_IDLE;
					end else if (!en) begin
						ph <= ph + 4'h1;
					end else begin
						cle_q <= (kind == nfc_pkg::PH_CMD) || (kind == nfc_pkg::PH_CMD2);
						ale_q <= (kind == nfc_pkg::PH_ADDR);
						rd_q <= (kind == nfc_pkg::PH_RD);
						byte_q <= (kind == nfc_pkg::PH_CMD) ? seg.cmd : seg.cmd2;
						case (kind)
							nfc_pkg::PH_ADDR: st <= nfc_pkg::ST_ISSUE;
							nfc_pkg::PH_WAIT: begin
								wbcnt <= 3'(`NFC_WB_CYC + `NFC_SYNC_CYC - 1);
								st <= nfc_pkg::ST_WB;
							end
							default: st <= nfc_pkg::ST_GAP;
						endcase
					end
				end
				nfc_pkg::ST_GAP: begin
					if (gapcnt != 2'h0) begin
						gapcnt <= gapcnt - 2'h1;
					end else begin
						st <= (kind == nfc_pkg::PH_WR) ? nfc_pkg::ST_WRHS : nfc_pkg::ST_ISSUE;
					end
				end
				nfc_pkg::ST_WRHS: begin
					if (wr_valid && !wr_ready) begin
						wr_ready <= 1'b1;
					end
					if (wr_valid && wr_ready) begin
						byte_q <= wr_data;
						st <= nfc_pkg::ST_ISSUE;
					end
				end
				nfc_pkg::ST_ISSUE: begin
					req_q <= 1'b1;
					if (kind == nfc_pkg::PH_ADDR) begin
						wbyte_q <= addr_byte(seg.addr, sub[2:0],
							((ph >= `NFC_PH_SEG) && plan.pa.cmd_en && seg.addr != nfc_pkg::A_COL) ?
							row2 : row, col);
					end else begin
						wbyte_q <= byte_q;
					end
					st <= nfc_pkg::ST_CYC;
				end
				nfc_pkg::ST_CYC: begin
					if (cyc.done) begin
						if (kind == nfc_pkg::PH_RD) begin
							rd_data <= cyc.rbyte;
							rd_valid <= 1'b1;
						end
						if ((kind == nfc_pkg::PH_ADDR || kind == nfc_pkg::PH_WR
							|| kind == nfc_pkg::PH_RD) && sub != last) begin
							sub <= sub + 1'b1;
							st <= (kind == nfc_pkg::PH_WR) ? nfc_pkg::ST_WRHS : nfc_pkg::ST_ISSUE;
						end else begin
							ph <= ph + 4'h1;
							st <= nfc_pkg::ST_PHASE;
						end
					end
				end
				nfc_pkg::ST_WB: begin
					if (wbcnt != 3'h0) begin
						wbcnt <= wbcnt - 3'h1;
					end else begin
						st <= nfc_pkg::ST_RB;
					end
				end
				nfc_pkg::ST_RB: begin
					// nothing else is sent while the device reports busy
					if (cyc.rb) begin
						ph <= ph + 4'h1;
						st <= nfc_pkg::ST_PHASE;
					end
				end
				default: begin
					st <= nfc_pkg::ST_IDLE;
				end
			endcase
		end
	end
endmodule

/* verilog/nfc_host_end.sv */
// spare design file: holds no logic, the controller lives in its two modules

/* sim/nfc_host_assertions.sv */
// concurrent checks on the host controller top-level ports
`timescale 1ns/1ps
module nfc_host_assertions (
	input logic clk,
	input logic resetn,
	input logic req_ready,
	input logic done,
	input logic refused,
	input logic write_protect,
	input logic nand_ce_n,
	input logic nand_cle,
	input logic nand_ale,
	input logic nand_we_n,
	input logic read_strobe_n,
	input logic nand_wp_n,
	input logic nand_io_oe
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	a_wp_follow: assert property ($past(resetn) |-> nand_wp_n != $past(write_protect))
		else $error("wp lag");
	a_we_pulse: assert property ($fell(nand_we_n) |=> $rose(nand_we_n))
		else $error("we width");
	a_rs_width: assert property ($fell(read_strobe_n) |=> !read_strobe_n [*2] ##1 read_strobe_n)
		else $error("rs width");
	a_no_fight: assert property (!read_strobe_n |-> !nand_io_oe)
		else $error("bus fight");
	a_sel_strobe: assert property (!(nand_we_n && read_strobe_n) |-> !nand_ce_n)
		else $error("strobe unselected");
	a_latch_excl: assert property (!(nand_cle && nand_ale))
		else $error("cle and ale");
	a_refuse_quiet: assert property (refused |-> nand_ce_n && $past(nand_ce_n))
		else $error("refused op on pins");
	a_ready_back: assert property (done |-> !req_ready ##[1:2] req_ready)
		else $error("ready late");
	c_done: cover property (done);
	c_refused: cover property (refused);
	c_read: cover property ($fell(read_strobe_n));
endmodule
bind nfc_host nfc_host_assertions u_chk (.*);

/* sim/nfc_flash_model.sv */
// behavioural flash: commands, address, read data, status, ready/busy
`timescale 1ns/1ps
module nfc_flash_model (
	input logic clk,
	input logic nand_ce_n,
	input logic nand_cle,
	input logic nand_ale,
	input logic nand_we_n,
	input logic read_strobe_n,
	input logic nand_wp_n,
	input logic [7:0] nand_io_in,
	input logic [7:0] busy_len,
	output logic [7:0] dq,
	output logic doe,
	output logic rb_low,
	output logic [7:0] cmd,
	output logic [39:0] adr,
	output logic [7:0] wdat
);
	logic [7:0] bcnt = 0;
	logic [2:0] nadr = 0;
	logic [12:0] col = 0;
	wire [7:0] io = nand_io_in;
	assign doe = !nand_ce_n && !read_strobe_n;
	// busy ignores chip select so a deselect cannot cut it short
	assign rb_low = bcnt != 0;
	always @(posedge clk) if (bcnt != 0) bcnt <= bcnt - 8'h01;
	always @(posedge nand_we_n) begin
		if (!nand_ce_n && nand_cle && (!rb_low || io inside {8'hFF, 8'h70, 8'hF1})) begin
			cmd <= io;
			nadr <= 0;
			if (io inside {8'hFF, 8'h30, 8'h35, 8'h33, 8'h31, 8'h3F}
				|| (nand_wp_n && io inside {8'h10, 8'h15, 8'hD0}))
				bcnt <= busy_len;
		end
		if (nand_ale && nadr < 5) begin
			adr[nadr*8+:8] <= io;
			nadr <= nadr + 3'h1;
			if (nadr == 1) col <= {io[4:0], adr[7:0]};
		end
		// data byte: both latches low, chip selected
		if (!nand_ce_n && !nand_cle && !nand_ale) wdat <= io;
	end
	always @(negedge read_strobe_n) begin
		dq <= cmd inside {8'h70, 8'hF1} ? {nand_wp_n, !rb_low, 6'h00} : col[7:0];
		col <= col + 13'h1;
	end
endmodule

/* sim/tb.sv */
// bench: host controller against the behavioural flash
`timescale 1ns/1ps
module tb;
	logic clk = 0;
	logic resetn = 0;
	logic req_valid = 0;
	logic wr_valid = 1;
	logic bad_wr = 0;
	logic write_protect = 0;
	logic rf = 0;
	logic bz = 0;
	logic wt = 0;
	nfc_pkg::nfc_op_e req_op = nfc_pkg::OP_RESET;
	logic [17:0] req_row = 0;
	logic [17:0] req_row2 = 0;
	logic [12:0] req_col = 0;
	logic [12:0] req_len = 0;
	logic [7:0] wr_data = 0;
	logic [11:0] bad_blk = 0;
	logic [7:0] busy_len = 8'h10;
	logic req_ready, rd_valid, done, refused, wr_ready, nand_ce_n, nand_cle, nand_ale;
	logic nand_we_n, read_strobe_n, nand_wp_n, nand_io_oe, nand_rb_n, doe, rb_low;
	logic [7:0] rd_data, nand_io_out, nand_io_in, dq, cmd, wdat;
	logic [39:0] adr;
	logic [7:0] rq[$];
	int fail_count = 0;
	int checked = 0;
	int cyc = 0;
	nfc_host u_dut (.*);
	nfc_flash_model u_mem (.*);
	assign nand_rb_n = !rb_low;
	// undriven bus toggles so a stale byte can never pass as data
	assign nand_io_in = nand_io_oe ? nand_io_out : doe ? dq : {4{clk, !clk}};
	always #20 clk = !clk;
	always @(negedge clk) begin
		// next write byte is offered only once the pending one has been taken
		if (wr_ready) begin
			wt = 1;
		end else if (wt) begin
			wt = 0;
			wr_data = wr_data + 8'h01;
		end
		if (rd_valid) rq.push_back(rd_data);
		if (refused) rf = 1;
		if (rb_low) bz = 1;
		cyc++;
		if (cyc == 4000) begin
			fail_count++;
			close_out();
		end
	end
	task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic run(input nfc_pkg::nfc_op_e o, input logic [17:0] r, input logic [12:0] c, l);
		rq = {};
		rf = 0;
		bz = 0;
		req_op = o;
		req_row = r;
		req_col = c;
		req_len = l;
		req_valid = 1;
		while (req_ready !== 1) @(negedge clk);
		@(negedge clk);
		req_valid = 0;
		while (done !== 1 && refused !== 1) @(negedge clk);
		@(negedge clk);
	endtask
	task automatic t_read();
		run(nfc_pkg::OP_RESET, 0, 0, 0);
		chk("rst cmd", 8'hFF, cmd);
		chk("rst busy", 1, bz);
		run(nfc_pkg::OP_READ, 18'h2ABCD, 13'h0FFE, 3);
		chk("rd cmd", 8'h30, cmd);
		chk("addr", 40'h02ABCD0FFE, adr);
		chk("data", 24'hFEFF00, {rq[0], rq[1], rq[2]});
		$display("t_read end");
	endtask
	task automatic t_refuse();
		run(nfc_pkg::OP_READ, 0, 13'd4313, 2);
		chk("over", 1, rf);
		bad_blk = 12'h123;
		bad_wr = 1;
		@(negedge clk);
		bad_wr = 0;
		run(nfc_pkg::OP_ERASE, {12'h123, 6'h00}, 0, 0);
		chk("bad", 1, rf);
		run(nfc_pkg::OP_TP_RAND_OUT, 0, 0, 1);
		chk("tp early", 1, rf);
		$display("t_refuse end");
	endtask
	task automatic t_tp();
		busy_len = 8'hC8;
		run(nfc_pkg::OP_ERASE, 18'h11583, 0, 0);
		chk("er cmd", 8'hD0, cmd);
		chk("er row", 24'h011583, adr[23:0]);
		busy_len = 8'h04;
		req_row2 = 18'h20C5A;
		run(nfc_pkg::OP_TP_READ, 18'h00080, 0, 0);
		chk("tp cmd", 8'h30, cmd);
		chk("tp row2", 24'h020C5A, adr[23:0]);
		run(nfc_pkg::OP_TP_RAND_OUT, 18'h00080, 13'h0005, 1);
		chk("tp ok", 0, rf);
		chk("out cmd", 8'hE0, cmd);
		chk("out data", 8'h05, rq[0]);
		$display("t_tp end");
	endtask
	task automatic t_prog();
		run(nfc_pkg::OP_PROG, 18'h00041, 13'h0010, 2);
		chk("pg cmd", 8'h10, cmd);
		chk("pg data", 8'h01, wdat);
		run(nfc_pkg::OP_PROG_CACHE, 18'h00042, 0, 1);
		chk("cache cmd", 8'h15, cmd);
		chk("cache data", 8'h02, wdat);
		run(nfc_pkg::OP_CB_PROG, 18'h00043, 0, 1);
		chk("cb cmd", 8'h10, cmd);
		chk("cb no data", 8'h02, wdat);
		write_protect = 1;
		run(nfc_pkg::OP_ERASE, 0, 0, 0);
		chk("blk0 ok", 0, rf);
		chk("wp busy", 0, bz);
		run(nfc_pkg::OP_STATUS, 0, 0, 0);
		chk("wp status", 8'h40, rq[0]);
		write_protect = 0;
		$display("t_prog end");
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (4) @(negedge clk);
		resetn = 1;
		@(negedge clk);
		t_read();
		t_refuse();
		t_tp();
		t_prog();
		close_out();
	end
endmodule
